//--- verilog/fcd_command_decoder.sv
// command decoder of a parallel NOR flash: read states, program/erase starts,
// suspend and resume, and the status flags
// assumes host writes arrive as one-cycle strobes on clk and that the write
// sequencer reports completion on clk; chip select and strobes are raw pins
// Notes on behaviour
// R1: code FF selects array reads.
// R2: code 70 selects status reads on the low byte.
// R3: any program or erase start switches reads to status by itself.
// R4: code 90 selects identifier reads on all sixteen lines.
// R5: code 98 selects query reads on the low byte.
// R6: sequencer only sets error flags; only code 50 clears them.
// R7: after 40 the next write's address and data are programmed once.
// R8: while programming only status read and suspend are honoured.
// R9: async reads see fresh status only after chip select or output enable toggles.
// R10: sync non-array reads refresh status on chip select or address-valid toggle.
// R11: host must issue FF after programming; status reads persist.
// R12: code 10 behaves exactly like 40.
// R13: code E8 opens a buffered load of at most 32 words.
// R14: confirm D0 after the load starts the buffered program.
// R15: 80 arms bulk program awaiting D0; bulk mode then ignores commands.
// R16: D0 right after 80 latches address and data for bulk mode.
// R17: non-D0 after erase setup sets flags 4 and 5, selects status reads.
// R18: D0 after erase setup latches the block address and starts erase.
// R19: while erasing only status read and suspend are honoured.
// R20: B0 suspends; flag 2 or 6 sets together with ready flag 7.
// R21: a suspended sequencer stays suspended until a D0 write resumes it.
// R22: D0 while suspended resumes the suspended operation.
// R23: reset gives array reads and status flags 80.
// R24: second buffered write carries word count minus one.
// R25: commands decode from the low data byte; others ignored when busy.
`default_nettype none
module fcd_command_decoder
  import fcd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_we,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [DATA_W-1:0] cmd_data,
  input wire logic sync_mode,
  input wire logic ce_n_pin,
  input wire logic oe_n_pin,
  input wire logic address_valid_n_pin,
  input wire logic seq_done,
  input wire logic seq_fail,
  output fcd_read_t read_state,
  output logic [7:0] status_flags,
  output logic [7:0] status_view,
  output logic op_start,
  output fcd_op_t op_kind,
  output logic [ADDR_W-1:0] op_addr,
  output logic [DATA_W-1:0] op_data,
  output logic seq_suspend,
  output logic [BUF_IDX_W-1:0] buf_count,
  output logic buf_wr,
  output logic [BUF_IDX_W-1:0] buf_index,
  output logic [DATA_W-1:0] buf_wdata
);

  fcd_state_t state;
  fcd_state_t next_state;
  logic [BUF_IDX_W-1:0] buf_left;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [2:0] pin_stable;

  ////////////////////////////////////////////////////////////////////////////
  // command decode on the low data byte
  wire [7:0] cmd = cmd_data[7:0]; // R25
  wire is_ff = cmd == CMD_READ_ARRAY;
  wire is_status = cmd == CMD_READ_STATUS;
  wire is_id = cmd == CMD_READ_ID;
  wire is_query = cmd == CMD_READ_QUERY;
  wire is_clear = cmd == CMD_CLEAR_STATUS;
  wire is_prog = (cmd == CMD_PROG_SETUP) || (cmd == CMD_PROG_SETUP_ALT); // R12
  wire is_buf = cmd == CMD_BUF_PROG;
  wire is_bulk = cmd == CMD_BULK_SETUP;
  wire is_erase = cmd == CMD_ERASE_SETUP;
  wire is_confirm = cmd == CMD_CONFIRM;
  wire is_suspend = cmd == CMD_SUSPEND;
  // groups of states; data-carrying states swallow every write as data
  wire st_free = (state == ST_IDLE);
  wire st_susp = (state == ST_PROG_SUSP) || (state == ST_ERASE_SUSP);
  wire st_busy = (state == ST_PROG_BUSY) || (state == ST_ERASE_BUSY);
  wire takes_cmds = st_free || st_susp || st_busy;
  // busy states honour only status read and suspend
  wire read_ok = st_busy ? is_status : (st_free || st_susp); // R8 R19
  wire clear_ok = cmd_we && is_clear && (st_free || st_susp); // R6
  wire count_bad = cmd_data[DATA_W-1:BUF_IDX_W] != '0;

  ////////////////////////////////////////////////////////////////////////////
  // next state; a start or a sequence error is derived from the transition
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_we && is_prog) begin
          next_state = ST_PROG_SETUP; // R7
        end else if (cmd_we && is_buf) begin
          next_state = ST_BUF_COUNT; // R13
        end else if (cmd_we && is_bulk) begin
          next_state = ST_BULK_SETUP; // R15
        end else if (cmd_we && is_erase) begin
          next_state = ST_ERASE_SETUP;
        end
      end
      ST_PROG_SETUP: if (cmd_we) next_state = ST_PROG_BUSY; // R7
      ST_BUF_COUNT: if (cmd_we) next_state = count_bad ? ST_IDLE : ST_BUF_DATA; // R24
      ST_BUF_DATA: if (cmd_we && buf_left == '0) next_state = ST_BUF_CONFIRM;
      ST_BUF_CONFIRM: if (cmd_we) next_state = is_confirm ? ST_PROG_BUSY : ST_IDLE; // R14
      ST_BULK_SETUP: if (cmd_we) next_state = is_confirm ? ST_BULK_BUSY : ST_IDLE; // R16
      ST_ERASE_SETUP: if (cmd_we) next_state = is_confirm ? ST_ERASE_BUSY : ST_IDLE; // R17 R18
      ST_PROG_BUSY: begin
        if (seq_done) begin
          next_state = ST_IDLE; // R11
        end else if (cmd_we && is_suspend) begin
          next_state = ST_PROG_SUSP; // R20
        end
      end
      ST_ERASE_BUSY: begin
        if (seq_done) begin
          next_state = ST_IDLE;
        end else if (cmd_we && is_suspend) begin
          next_state = ST_ERASE_SUSP; // R20
        end
      end
      ST_BULK_BUSY: if (seq_done) next_state = ST_IDLE; // R15
      ST_PROG_SUSP: if (cmd_we && is_confirm) next_state = ST_PROG_BUSY; // R21 R22
      ST_ERASE_SUSP: if (cmd_we && is_confirm) next_state = ST_ERASE_BUSY; // R21 R22
      default: next_state = ST_IDLE;
    endcase
  end

  // a bad second cycle is a sequence error for every two-cycle command
  wire seq_err = cmd_we && next_state == ST_IDLE &&
    (state == ST_BUF_COUNT || state == ST_BUF_CONFIRM || state == ST_BULK_SETUP ||
     state == ST_ERASE_SETUP); // R17
  wire next_busy = next_state == ST_PROG_BUSY || next_state == ST_ERASE_BUSY ||
    next_state == ST_BULK_BUSY;
  // a start is entry to a busy state from anything but suspend
  wire next_start = next_busy && !st_susp && !st_busy && state != ST_BULK_BUSY;
  wire fail_prog = seq_done && seq_fail && (state == ST_PROG_BUSY || state == ST_BULK_BUSY);
  wire fail_erase = seq_done && seq_fail && state == ST_ERASE_BUSY;

  ////////////////////////////////////////////////////////////////////////////
  // status flags: errors are sticky, set beats the clear of the same cycle
  wire next_prog_err = fail_prog || seq_err || (status_flags[SF_PROG_ERR] && !clear_ok); // R6
  wire next_erase_err = fail_erase || seq_err || (status_flags[SF_ERASE_ERR] && !clear_ok); // R6
  wire [7:0] next_status = {!next_busy, next_state == ST_ERASE_SUSP, next_erase_err,
    next_prog_err, 1'b0, next_state == ST_PROG_SUSP, 2'b00}; // R20

  ////////////////////////////////////////////////////////////////////////////
  // read state; programs, erases and sequence errors fall back to status
  fcd_read_t next_read;
  always_comb begin
    next_read = read_state;
    if (next_start || seq_err) begin
      next_read = RD_STATUS; // R3 R17
    end else if (cmd_we && takes_cmds && read_ok) begin
      if (is_ff) next_read = RD_ARRAY; // R1
      else if (is_status) next_read = RD_STATUS; // R2
      else if (is_id) next_read = RD_ID; // R4
      else if (is_query) next_read = RD_QUERY; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; a change counts once the second and third stages agree
  wire [2:0] pins = {address_valid_n_pin, oe_n_pin, ce_n_pin};
  wire [2:0] pin_change = ~(pin_s2 ^ pin_s3) & (pin_s3 ^ pin_stable);
  // async reads refresh on CE or OE, sync non-array reads on CE or ADV
  wire refresh = pin_change[0] || (sync_mode ? pin_change[2] : pin_change[1]); // R9 R10
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
      pin_stable <= PIN_IDLE;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_stable <= pin_stable ^ pin_change;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control state and status; the view only moves on a synchronised control-pin toggle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE; // R23
      read_state <= RD_ARRAY; // R23
      status_flags <= STATUS_RESET; // R23
      status_view <= STATUS_RESET;
      seq_suspend <= 1'b0;
    end else begin
      state <= next_state;
      read_state <= next_read;
      status_flags <= next_status;
      seq_suspend <= next_state == ST_PROG_SUSP || next_state == ST_ERASE_SUSP; // R21
      if (refresh) status_view <= status_flags; // R9 R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation start; address and data of the confirming write are latched
  wire [1:0] start_kind = (state == ST_PROG_SETUP) ? OP_WORD :
    (state == ST_BUF_CONFIRM) ? OP_BUFFER : (state == ST_BULK_SETUP) ? OP_BULK : OP_ERASE;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_start <= 1'b0;
      op_kind <= OP_WORD;
      op_addr <= '0;
      op_data <= '0;
    end else begin
      op_start <= next_start; // R7 R14 R16 R18
      if (next_start) begin
        op_kind <= fcd_op_t'(start_kind);
        op_addr <= cmd_addr;
        op_data <= cmd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program buffer loading; bulk mode streams its data words the same way
  wire load_word = cmd_we && (state == ST_BUF_DATA || state == ST_BULK_BUSY); // R13 R15
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buf_count <= '0;
      buf_left <= '0;
      buf_wr <= 1'b0;
      buf_index <= '0;
      buf_wdata <= '0;
    end else begin
      buf_wr <= load_word;
      if (cmd_we && state == ST_BUF_COUNT) begin
        buf_count <= cmd_data[BUF_IDX_W-1:0]; // R24
        buf_left <= cmd_data[BUF_IDX_W-1:0];
        buf_index <= '0;
      end else if (next_start) begin
        buf_index <= '0;
      end else if (load_word) begin
        buf_left <= buf_left - 5'h01;
        buf_index <= buf_index + 5'h01; // a full 32-word load wraps cleanly
        buf_wdata <= cmd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks next to the logic
  property p_read_array;
    @(posedge clk) disable iff (!arst_n)
    cmd_we && is_ff && (st_free || st_susp) |=> read_state == RD_ARRAY;
  endproperty
  a_read_array: assert property (p_read_array) else $error("array read not selected"); // R1
  property p_read_status;
    @(posedge clk) disable iff (!arst_n)
    cmd_we && is_status && takes_cmds |=> read_state == RD_STATUS;
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read not selected"); // R2
  property p_auto_status;
    @(posedge clk) disable iff (!arst_n)
    op_start |-> read_state == RD_STATUS && !status_flags[SF_READY];
  endproperty
  a_auto_status: assert property (p_auto_status) else $error("start without status read"); // R3
  property p_read_id;
    @(posedge clk) disable iff (!arst_n)
    cmd_we && is_id && st_free |=> read_state == RD_ID;
  endproperty
  a_read_id: assert property (p_read_id) else $error("id read not selected"); // R4
  property p_read_query;
    @(posedge clk) disable iff (!arst_n)
    cmd_we && is_query && st_free |=> read_state == RD_QUERY;
  endproperty
  a_read_query: assert property (p_read_query) else $error("query read not selected"); // R5
  property p_err_sticky;
    @(posedge clk) disable iff (!arst_n)
    $fell(status_flags[SF_PROG_ERR]) |-> $past(clear_ok);
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag cleared without 50"); // R6
  property p_word_prog;
    @(posedge clk) disable iff (!arst_n)
    state == ST_PROG_SETUP && cmd_we |=> op_start && op_kind == OP_WORD && op_data == $past(cmd_data);
  endproperty
  a_word_prog: assert property (p_word_prog) else $error("word program not started"); // R7
  property p_busy_ignore;
    @(posedge clk) disable iff (!arst_n)
    st_busy && cmd_we && !is_status && !is_suspend |=> !op_start && read_state == $past(read_state);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("busy decoder obeyed a command"); // R8
  property p_erase_seq_err;
    @(posedge clk) disable iff (!arst_n)
    state == ST_ERASE_SETUP && cmd_we && !is_confirm |=>
      status_flags[5:4] == 2'b11 && read_state == RD_STATUS && state == ST_IDLE;
  endproperty
  a_erase_seq_err: assert property (p_erase_seq_err) else $error("erase sequence error missed"); // R17
  property p_suspend;
    @(posedge clk) disable iff (!arst_n)
    state == ST_PROG_BUSY && cmd_we && is_suspend && !seq_done |=>
      status_flags[SF_PROG_SUSP] && status_flags[SF_READY] && seq_suspend;
  endproperty
  a_suspend: assert property (p_suspend) else $error("program suspend not flagged"); // R20
  property p_stay_susp;
    @(posedge clk) disable iff (!arst_n)
    state == ST_ERASE_SUSP && !(cmd_we && is_confirm) |=> state == ST_ERASE_SUSP [*2] or
      (state == ST_ERASE_SUSP ##1 state == ST_ERASE_BUSY);
  endproperty
  a_stay_susp: assert property (p_stay_susp) else $error("suspend left without resume"); // R21
  property p_resume;
    @(posedge clk) disable iff (!arst_n)
    state == ST_PROG_SUSP && cmd_we && is_confirm |=> state == ST_PROG_BUSY && !seq_suspend;
  endproperty
  a_resume: assert property (p_resume) else $error("resume ignored"); // R22
  property p_view_refresh;
    @(posedge clk) disable iff (!arst_n)
    status_view != $past(status_view) |-> $past(refresh);
  endproperty
  a_view_refresh: assert property (p_view_refresh) else $error("status view moved on its own"); // R9
  c_buf_prog: cover property (@(posedge clk) disable iff (!arst_n) op_start && op_kind == OP_BUFFER);
  c_erase_susp: cover property (@(posedge clk) disable iff (!arst_n) state == ST_ERASE_SUSP);
  c_bulk: cover property (@(posedge clk) disable iff (!arst_n) state == ST_BULK_BUSY && buf_wr);
  c_refresh: cover property (@(posedge clk) disable iff (!arst_n) refresh && sync_mode);

endmodule : fcd_command_decoder
`default_nettype wire

//--- inc/fcd_pkg.sv
// constants and types for the flash command decoder
// assumes one 250 MHz clock domain shared by the decoder and its write sequencer
`default_nettype none
package fcd_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BUF_IDX_W = 5;
  // command codes seen on the low data byte
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_BUF_PROG = 8'hE8;
  localparam logic [7:0] CMD_BULK_SETUP = 8'h80;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  // status flag bit positions and reset value
  localparam int SF_READY = 7;
  localparam int SF_ERASE_SUSP = 6;
  localparam int SF_ERASE_ERR = 5;
  localparam int SF_PROG_ERR = 4;
  localparam int SF_PROG_SUSP = 2;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic [2:0] PIN_IDLE = 3'h7;
  typedef enum logic [1:0] {
    RD_ARRAY = 2'b00, RD_STATUS = 2'b01, RD_ID = 2'b10, RD_QUERY = 2'b11
  } fcd_read_t;
  typedef enum logic [1:0] {
    OP_WORD = 2'b00, OP_BUFFER = 2'b01, OP_BULK = 2'b10, OP_ERASE = 2'b11
  } fcd_op_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_PROG_SETUP = 4'b0001, ST_BUF_COUNT = 4'b0010,
    ST_BUF_DATA = 4'b0011, ST_BUF_CONFIRM = 4'b0100, ST_BULK_SETUP = 4'b0101,
    ST_ERASE_SETUP = 4'b0110, ST_PROG_BUSY = 4'b0111, ST_ERASE_BUSY = 4'b1000,
    ST_BULK_BUSY = 4'b1001, ST_PROG_SUSP = 4'b1010, ST_ERASE_SUSP = 4'b1011
  } fcd_state_t;
endpackage : fcd_pkg
`default_nettype wire

//--- verif/fcd_host_model.sv
// host model: drives decoder write cycles and the raw control pins
// assumes the bench calls its tasks from one process at a time
`default_nettype none
module fcd_host_model
  import fcd_pkg::*;
(
  input wire logic clk,
  output logic cmd_we,
  output logic [ADDR_W-1:0] cmd_addr,
  output logic [DATA_W-1:0] cmd_data,
  output logic ce_n_pin,
  output logic oe_n_pin,
  output logic address_valid_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins start deasserted so no refresh is seen at reset release
  initial begin
    cmd_we = 1'b0;
    cmd_addr = '0;
    cmd_data = '0;
    ce_n_pin = 1'b1;
    oe_n_pin = 1'b1;
    address_valid_n_pin = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // one write cycle; released bus shows the inverse so stale values never match
  // returns at the release edge so one-cycle answer pulses are still standing
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk);
    cmd_we = 1'b1;
    cmd_addr = a;
    cmd_data = d;
    @(negedge clk);
    cmd_we = 1'b0;
    cmd_addr = ~a;
    cmd_data = ~d;
  endtask : wr
  // pulse a pin low and back; slow enough for the 3-flop synchroniser
  task automatic toggle(input int which);
    repeat (2) begin
      @(negedge clk);
      case (which)
        0: ce_n_pin = ~ce_n_pin;
        1: oe_n_pin = ~oe_n_pin;
        default: address_valid_n_pin = ~address_valid_n_pin;
      endcase
      repeat (8) @(negedge clk);
    end
  endtask : toggle
endmodule : fcd_host_model
`default_nettype wire

//--- verif/test_flash_command_decoder.sv
// testbench for the flash command decoder: host model plus sequencer stub
// assumes the decoder answers a write one edge after taking it
`default_nettype none
module test_flash_command_decoder
  import fcd_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, cmd_we, sync_mode, ce_n_pin, oe_n_pin, address_valid_n_pin;
  logic seq_done, seq_fail, op_start, seq_suspend, buf_wr;
  logic [ADDR_W-1:0] cmd_addr, op_addr;
  logic [DATA_W-1:0] cmd_data, op_data, buf_wdata;
  logic [7:0] status_flags, status_view;
  logic [BUF_IDX_W-1:0] buf_count, buf_index;
  fcd_read_t read_state;
  fcd_op_t op_kind;
  int mismatches = 0;
  int checks = 0;
  logic [7:0] rd_code[5] = '{CMD_READ_STATUS, CMD_READ_ID, CMD_READ_QUERY, 8'h00, CMD_READ_ARRAY};
  fcd_read_t rd_exp[5] = '{RD_STATUS, RD_ID, RD_QUERY, RD_QUERY, RD_ARRAY};
  logic [7:0] sp_code[2] = '{CMD_ERASE_SETUP, CMD_PROG_SETUP};
  logic [15:0] sp_data[2] = '{16'h00D0, 16'h1234};
  fcd_op_t sp_kind[2] = '{OP_ERASE, OP_WORD};
  logic [7:0] sp_flags[2] = '{8'hC0, 8'h84};
  logic [7:0] pg_code[2] = '{CMD_PROG_SETUP, CMD_PROG_SETUP_ALT};

  fcd_command_decoder dut (.clk, .arst_n, .cmd_we, .cmd_addr, .cmd_data, .sync_mode, .ce_n_pin,
    .oe_n_pin, .address_valid_n_pin, .seq_done, .seq_fail, .read_state, .status_flags, .status_view,
    .op_start, .op_kind, .op_addr, .op_data, .seq_suspend, .buf_count, .buf_wr, .buf_index, .buf_wdata);
  fcd_host_model h (.clk, .cmd_we, .cmd_addr, .cmd_data, .ce_n_pin, .oe_n_pin, .address_valid_n_pin);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", n, exp, got);
    end
  endtask : chk
  // sequencer stub: one done pulse, then one edge for the flags to land
  task automatic seq_end(input logic fail);
    @(negedge clk);
    seq_done = 1'b1;
    seq_fail = fail;
    @(negedge clk);
    seq_done = 1'b0;
    seq_fail = 1'b0;
    @(negedge clk);
  endtask : seq_end
  task automatic give_verdict();
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // hang guard: a run this long means the sequence stalled
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    sync_mode = 1'b0;
    seq_done = 1'b0;
    seq_fail = 1'b0;
    repeat (5) @(negedge clk);
    chk("read_state", read_state, RD_ARRAY);
    chk("status_flags", status_flags, STATUS_RESET);
    arst_n = 1'b1;
    // erase setup without confirm; view waits for a pin refresh
    h.wr(24'h0, CMD_ERASE_SETUP);
    h.wr(24'h0, CMD_READ_ARRAY);
    chk("status_flags", status_flags, 8'hB0);
    chk("read_state", read_state, RD_STATUS);
    chk("status_view", status_view, 8'h80);
    h.toggle(1);
    chk("status_view", status_view, 8'hB0);
    sync_mode = 1'b1;
    h.wr(24'h0, CMD_CLEAR_STATUS);
    chk("status_flags", status_flags, 8'h80);
    h.toggle(1);
    chk("status_view", status_view, 8'hB0);
    h.toggle(2);
    chk("status_view", status_view, 8'h80);
    sync_mode = 1'b0;
    // every read state, with an unknown code in between
    foreach (rd_code[i]) begin
      h.wr(24'h1, {8'h00, rd_code[i]});
      chk("read_state", read_state, rd_exp[i]);
    end
    // word program by both setup codes; failure then success keeps the error
    foreach (pg_code[i]) begin
      h.wr(24'h123456, {8'h00, pg_code[i]});
      chk("op_start", op_start, 1'b0);
      h.wr(24'h00ABCD, 16'h5A3C);
      chk("op_start", op_start, 1'b1);
      chk("op_kind", op_kind, OP_WORD);
      chk("op_addr", op_addr, 24'h00ABCD);
      chk("op_data", op_data, 16'h5A3C);
      chk("read_state", read_state, RD_STATUS);
      chk("status_flags", status_flags, {1'b0, i ? 7'h10 : 7'h00});
      h.wr(24'h0, CMD_READ_ARRAY);
      h.wr(24'h0, CMD_CLEAR_STATUS);
      chk("read_state", read_state, RD_STATUS);
      seq_end(i == 0);
      chk("status_flags", status_flags, 8'h90);
      h.wr(24'h0, CMD_READ_ARRAY);
      chk("read_state", read_state, RD_ARRAY);
    end
    h.wr(24'h0, CMD_CLEAR_STATUS);
    chk("status_flags", status_flags, 8'h80);
    // suspend and resume an erase, then a program
    foreach (sp_code[i]) begin
      h.wr(24'h040000, {8'h00, sp_code[i]});
      h.wr(24'h040123, sp_data[i]);
      chk("op_kind", op_kind, sp_kind[i]);
      chk("op_addr", op_addr, 24'h040123);
      h.wr(24'h0, CMD_READ_ID);
      chk("read_state", read_state, RD_STATUS);
      h.wr(24'h777777, CMD_SUSPEND);
      chk("seq_suspend", seq_suspend, 1'b1);
      chk("status_flags", status_flags, sp_flags[i]);
      h.toggle(0);
      seq_end(1'b0);
      chk("seq_suspend", seq_suspend, 1'b1);
      h.wr(24'h0, CMD_CONFIRM);
      chk("seq_suspend", seq_suspend, 1'b0);
      chk("status_flags", status_flags, 8'h00);
      seq_end(1'b0);
    end
    // buffered program of three words, then an over-range count
    h.wr(24'h000100, CMD_BUF_PROG);
    h.wr(24'h000100, 16'h0002);
    chk("buf_count", buf_count, 5'h02);
    for (int w = 0; w < 3; w++) begin
      h.wr(24'h000100, 16'h1000 + w[15:0]);
      chk("buf_wr", buf_wr, 1'b1);
      chk("buf_index", buf_index, w[4:0] + 5'h01);
      chk("buf_wdata", buf_wdata, 16'h1000 + w[15:0]);
    end
    h.wr(24'h000100, CMD_CONFIRM);
    chk("op_start", op_start, 1'b1);
    chk("op_kind", op_kind, OP_BUFFER);
    seq_end(1'b0);
    h.wr(24'h0, CMD_BUF_PROG);
    h.wr(24'h0, 16'h0020);
    chk("status_flags", status_flags, 8'hB0);
    h.wr(24'h0, CMD_CLEAR_STATUS);
    // factory bulk: commands become buffer words
    h.wr(24'h0, CMD_BULK_SETUP);
    h.wr(24'h000200, CMD_CONFIRM);
    chk("op_kind", op_kind, OP_BULK);
    chk("op_addr", op_addr, 24'h000200);
    h.wr(24'h0, CMD_READ_ARRAY);
    chk("buf_wr", buf_wr, 1'b1);
    chk("buf_index", buf_index, 5'h01);
    chk("read_state", read_state, RD_STATUS);
    seq_end(1'b0);
    chk("status_flags", status_flags, 8'h80);
    give_verdict();
  end
endmodule : test_flash_command_decoder
`default_nettype wire
